/* bench/pic_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic core_irq,
  input wire logic hold,
  input wire logic [3:0] dly,
  output logic core_ack
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_ack;

  // The core answers dly+1 cycles after the request; hold keeps it busy so a request must wait.
  always_comb begin
    next_cnt = 4'h0;
    next_ack = 1'b0;
    if (core_irq && !core_ack && !hold) begin
      next_cnt = cnt + 4'h1;
      next_ack = (cnt >= dly);
    end
  end

  // Acknowledge lasts one cycle, so it is gone after the edge that took it.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      cnt <= next_cnt;
      core_ack <= next_ack;
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [127:8] hw_irq;
  logic nmi_in, core_irq, core_ack, core_crit, irq_out, hold;
  logic [8:0] core_vector;
  logic [3:0] dly;
  logic [31:0] rq[$];
  logic [8:0] vq[$];
  int fails, checks, a, l;
  int seed = 32'h2363;

  pic_controller dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hw_irq(hw_irq),
    .nmi_in(nmi_in), .core_irq(core_irq), .core_vector(core_vector),
    .core_ack(core_ack), .core_crit(core_crit), .irq_out(irq_out));
  pic_core_model core_u (.sys_clk(sys_clk), .arst_n(arst_n), .core_irq(core_irq),
    .hold(hold), .dly(dly), .core_ack(core_ack));

  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_rd(input logic [31:0] e);
    chk("readdata", e, avs_readdata);
  endtask

  task automatic chk_vec(input logic [8:0] e);
    chk("core_vector", 32'(e), 32'(core_vector));
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask

  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tmo;
    chk("wait", 32'h1, 32'h0);
    give_verdict;
  endtask

  // One bus access; the request stands until a rising edge samples waitrequest low.
  task automatic bus(input logic r, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) tmo;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    bus(1'b0, ad, d);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b1, ad, 32'h0);
  endtask

  task automatic setp(input int n, input logic [3:0] lv);
    wr(12'h400 + 12'(n * 4), {28'h0, lv});
  endtask

  task automatic eoi;
    wr(pic_pkg::OFF_EOI, 32'h0);
  endtask

  task automatic hw(input int n, input logic v);
    @(posedge sys_clk);
    hw_irq[n] <= v;
  endtask

  // Waits until every expected vector has been taken by the core.
  task automatic waitq;
    int k;
    for (k = 0; k < 200 && vq.size() != 0; k++) @(posedge sys_clk);
    if (vq.size() != 0) tmo;
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      chk_pin("core_irq", 1'b0, core_irq);
    end
  endtask

  // Full service of one source: request, acceptance, level check, end of service.
  task automatic serve(input int n, input logic [3:0] lv);
    setp(n, lv);
    dly <= 4'($random(seed));
    vq.push_back(9'(n));
    if (n < 8) wr(pic_pkg::OFF_SWSET, 32'h1 << n);
    else hw(n, 1'b1);
    waitq;
    rd(pic_pkg::OFF_CPR, {28'h0, lv});
    if (n < 8) wr(pic_pkg::OFF_SWSET, 32'h100 << n);
    else hw(n, 1'b0);
    eoi;
  endtask

  // Results are compared in the cycle they stand, oldest note first.
  always @(negedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      chk_rd(rq.size() ? rq.pop_front() : 'x);
    if (core_irq === 1'b1 && core_ack === 1'b1)
      chk_vec(vq.size() ? vq.pop_front() : 'x);
  end

  initial begin
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    hw_irq = '0;
    nmi_in = 1'b0;
    hold = 1'b0;
    dly = 4'h0;
    arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    quiet(1);
    rd(pic_pkg::OFF_CPR, 32'h0);
    rd(12'h5fc, 32'h0);
    rd(pic_pkg::OFF_EVMASK, 32'h0);
    wr(12'h020, 32'hffff);
    rd(12'h020, 32'h0);
    $display("test reset finished");
    serve(8, 4'h1);
    serve(127, 4'hf);
    repeat (5) serve(8 + $unsigned($random(seed)) % 120, 4'(1 + $unsigned($random(seed)) % 15));
    for (int i = 0; i < 8; i++) serve(i, 4'(1 + $unsigned($random(seed)) % 15));
    $display("test vectors finished");
    // Equal levels released together: the lower index goes first.
    a = 8 + $unsigned($random(seed)) % 100;
    l = 1 + $unsigned($random(seed)) % 15;
    wr(pic_pkg::OFF_CPR, 32'hf);
    setp(a, 4'(l));
    setp(a + 9, 4'(l));
    hw(a + 9, 1'b1);
    hw(a, 1'b1);
    quiet(4);
    vq.push_back(9'(a));
    wr(pic_pkg::OFF_CPR, 32'h0);
    waitq;
    hw(a, 1'b0);
    vq.push_back(9'(a + 9));
    eoi;
    waitq;
    hw(a + 9, 1'b0);
    eoi;
    $display("test tie finished");
    // A lower request waits behind the running level, a higher one preempts.
    setp(30, 4'h3);
    setp(40, 4'h9);
    setp(50, 4'h2);
    vq.push_back(9'd30);
    hw(30, 1'b1);
    waitq;
    hw(50, 1'b1);
    quiet(10);
    vq.push_back(9'd40);
    hw(40, 1'b1);
    waitq;
    rd(pic_pkg::OFF_CPR, 32'h9);
    hw(40, 1'b0);
    eoi;
    hw(30, 1'b0);
    vq.push_back(9'd50);
    eoi;
    waitq;
    hw(50, 1'b0);
    eoi;
    $display("test preempt finished");
    // The current level blocks requests at or below it.
    wr(pic_pkg::OFF_CPR, 32'h7);
    setp(60, 4'h7);
    setp(61, 4'h8);
    hw(60, 1'b1);
    quiet(8);
    vq.push_back(9'd61);
    hw(61, 1'b1);
    waitq;
    hw(61, 1'b0);
    eoi;
    vq.push_back(9'd60);
    wr(pic_pkg::OFF_CPR, 32'h0);
    waitq;
    hw(60, 1'b0);
    eoi;
    $display("test mask finished");
    // An unanswered request keeps its vector even when a higher one arrives.
    hold <= 1'b1;
    setp(70, 4'h4);
    setp(71, 4'hc);
    vq.push_back(9'd70);
    hw(70, 1'b1);
    hw(71, 1'b1);
    repeat (2) @(posedge sys_clk);
    repeat (8) begin
      @(negedge sys_clk);
      chk_pin("core_irq", 1'b1, core_irq);
      chk_vec(9'd70);
    end
    // Status word: vector 70, request pending, no saved levels.
    rd(pic_pkg::OFF_VEC, 32'h0001_0046);
    vq.push_back(9'd71);
    @(posedge sys_clk);
    hold <= 1'b0;
    waitq;
    hw(70, 1'b0);
    hw(71, 1'b0);
    eoi;
    eoi;
    $display("test hold finished");
    // Non-maskable path ignores the level; its event drives irq_out when unmasked.
    wr(pic_pkg::OFF_EVT, 32'h7);
    wr(pic_pkg::OFF_CPR, 32'hf);
    nmi_in <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk_pin("core_crit", 1'b1, core_crit);
    quiet(1);
    chk_pin("irq_out", 1'b0, irq_out);
    @(posedge sys_clk);
    nmi_in <= 1'b0;
    rd(pic_pkg::OFF_EVT, 32'h1);
    wr(pic_pkg::OFF_EVMASK, 32'h1);
    @(negedge sys_clk);
    chk_pin("irq_out", 1'b1, irq_out);
    chk_pin("core_crit", 1'b0, core_crit);
    wr(pic_pkg::OFF_EVT, 32'h1);
    @(negedge sys_clk);
    chk_pin("irq_out", 1'b0, irq_out);
    // End of service with nothing saved flags the stack and keeps the level.
    eoi;
    rd(pic_pkg::OFF_EVT, 32'h4);
    rd(pic_pkg::OFF_CPR, 32'hf);
    $display("test nmi finished");
    // A reset in mid-run drops the presented request and every programmed level.
    hold <= 1'b1;
    wr(pic_pkg::OFF_CPR, 32'h0);
    setp(90, 4'h5);
    hw(90, 1'b1);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk_pin("core_irq", 1'b1, core_irq);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    hold <= 1'b0;
    quiet(4);
    rd(pic_pkg::OFF_EVMASK, 32'h0);
    rd(12'h568, 32'h0);
    rd(pic_pkg::OFF_CPR, 32'h0);
    hw(90, 1'b0);
    $display("test mid reset finished");
    give_verdict;
  end
endmodule
`default_nettype wire

/* hw/pic_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_arbiter (
  input wire logic [127:0] pend,
  input wire logic [511:0] prio_flat,
  input wire logic [3:0] cur,
  output logic found,
  output logic [6:0] idx,
  output logic [3:0] lvl
);
  // Scan from the top index down with >= so that on equal levels the lowest index wins.
  always_comb begin
    logic [3:0] p;
    p = 4'h0;
    found = 1'b0;
    idx = 7'h00;
    lvl = 4'h0;
    for (int i = pic_pkg::NSRC - 1; i >= 0; i--) begin
      p = prio_flat[i*pic_pkg::PRIO_W +: pic_pkg::PRIO_W];
      if (pend[i] && (p > cur) && (p >= lvl)) begin // R2 R5
        found = 1'b1;
        idx = 7'(i);
        lvl = p;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/pic_controller.sv */
// Notes on behaviour
// R1 - Up to 128 sources, each presented to the core as its own 9-bit vector.
// R2 - Sixteen levels per source; ties inside a level go to the lowest index.
// R3 - Each source's level is software programmable and used in every decision.
// R4 - Only requests above the current level interrupt; lower ones wait.
// R5 - Writable current level masks every request at or below it.
// R6 - Eight software-set sources arbitrate exactly like wired requests.
// R7 - Non-maskable input drives the critical interrupt directly, bypassing all arbitration.
// R8 - Request and vector hold until acknowledge; acknowledge raises current level.
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pic_controller (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [127:8] hw_irq,
  input wire logic nmi_in,
  output logic core_irq,
  output logic [8:0] core_vector,
  input wire logic core_ack,
  output logic core_crit,
  output logic irq_out
);
  logic bus_done;
  logic next_bus_done;
  logic [31:0] next_readdata;
  logic wr_en;
  logic [3:0] cpr;
  logic [3:0] next_cpr;
  logic [7:0] sw_flag;
  logic [7:0] next_sw_flag;
  logic [2:0] ev_status;
  logic [2:0] next_ev_status;
  logic [2:0] ev_mask;
  logic [2:0] next_ev_mask;
  logic [2:0] ev_set;
  logic nmi_q;
  logic [3:0] prio_mem [pic_pkg::NSRC];
  logic [511:0] prio_flat;
  logic [127:0] pend;
  logic win_found;
  logic [6:0] win_idx;
  logic [3:0] win_lvl;
  pic_pkg::pic_req_state_t state;
  pic_pkg::pic_req_state_t next_state;
  logic [6:0] req_idx;
  logic [6:0] next_req_idx;
  logic [3:0] req_lvl;
  logic [3:0] next_req_lvl;
  logic ack_take;
  logic eoi_wr;
  logic [3:0] stk_top;
  logic [4:0] stk_depth;
  logic stk_err;

  // Every access waits exactly one cycle, which keeps read data registered.
  assign avs_waitrequest = (avs_read || avs_write) && !bus_done;
  assign wr_en = avs_write && bus_done;
  assign eoi_wr = wr_en && (avs_address == pic_pkg::OFF_EOI);

  // Bus phase and read data are computed in the waiting cycle and held at the answer.
  always_comb begin
    next_bus_done = (avs_read || avs_write) && !bus_done;
    next_readdata = avs_readdata;
    if (avs_read && !bus_done) begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
        pic_pkg::OFF_CPR: next_readdata[3:0] = cpr;
        pic_pkg::OFF_VEC: begin
          next_readdata[8:0] = core_vector;
          next_readdata[pic_pkg::VEC_PEND_BIT] = core_irq;
          next_readdata[pic_pkg::VEC_DEPTH_LSB +: 5] = stk_depth;
        end
        pic_pkg::OFF_SWSET: next_readdata[7:0] = sw_flag;
        pic_pkg::OFF_EVT: next_readdata[2:0] = ev_status;
        pic_pkg::OFF_EVMASK: next_readdata[2:0] = ev_mask;
        default: begin
          if (pic_pkg::pic_is_prio(avs_address)) begin
            next_readdata[3:0] = prio_mem[avs_address[8:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_done <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_done <= next_bus_done;
      avs_readdata <= next_readdata;
    end
  end

  // Per-source levels; software may retune any source at any time.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < pic_pkg::NSRC; i++) begin
        prio_mem[i] <= pic_pkg::PRIO_RST;
      end
    end else if (wr_en && pic_pkg::pic_is_prio(avs_address)) begin
      prio_mem[avs_address[8:2]] <= avs_writedata[3:0]; // R3
    end
  end

  // Software flags: low byte of a write sets, next byte clears; a set wins a clash.
  always_comb begin
    next_sw_flag = sw_flag;
    if (wr_en && (avs_address == pic_pkg::OFF_SWSET)) begin
      next_sw_flag = (sw_flag & ~avs_writedata[pic_pkg::SW_CLR_LSB +: 8])
        | avs_writedata[7:0]; // R6
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_flag <= 8'h00;
    end else begin
      sw_flag <= next_sw_flag;
    end
  end

  // Software flags occupy the lowest indices, so they win ties inside a level.
  always_comb begin
    pend = {hw_irq, sw_flag}; // R6
    for (int i = 0; i < pic_pkg::NSRC; i++) begin
      prio_flat[i*pic_pkg::PRIO_W +: pic_pkg::PRIO_W] = prio_mem[i]; // R3
    end
  end

  pic_arbiter u_arb (
    .pend(pend),
    .prio_flat(prio_flat),
    .cur(cpr),
    .found(win_found),
    .idx(win_idx),
    .lvl(win_lvl)
  );

  // Once presented, the vector is frozen; a later higher request waits for the
  // acknowledge rather than swapping the vector under the core.
  always_comb begin
    next_state = state;
    next_req_idx = req_idx;
    next_req_lvl = req_lvl;
    ack_take = 1'b0;
    case (state)
      pic_pkg::PIC_IDLE: begin
        if (win_found) begin // R4
          next_state = pic_pkg::PIC_PRESENT;
          next_req_idx = win_idx;
          next_req_lvl = win_lvl;
        end
      end
      pic_pkg::PIC_PRESENT: begin
        if (core_ack) begin // R8
          ack_take = 1'b1;
          next_state = pic_pkg::PIC_IDLE;
        end
      end
      default: next_state = pic_pkg::PIC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= pic_pkg::PIC_IDLE;
      req_idx <= 7'h00;
      req_lvl <= 4'h0;
    end else begin
      state <= next_state;
      req_idx <= next_req_idx;
      req_lvl <= next_req_lvl;
    end
  end

  assign core_irq = state == pic_pkg::PIC_PRESENT; // R8
  assign core_vector = {2'b00, req_idx}; // R1

  // Current level: acknowledge beats end of service, which beats a plain write.
  always_comb begin
    next_cpr = cpr;
    if (ack_take) begin
      next_cpr = req_lvl; // R8
    end else if (eoi_wr) begin
      if (stk_depth != 5'h00) begin
        next_cpr = stk_top;
      end
    end else if (wr_en && (avs_address == pic_pkg::OFF_CPR)) begin
      next_cpr = avs_writedata[3:0]; // R5
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpr <= pic_pkg::CPR_RST;
    end else begin
      cpr <= next_cpr;
    end
  end

  pic_level_stack u_stk (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .push(ack_take),
    .pop(eoi_wr),
    .push_lvl(cpr),
    .top(stk_top),
    .depth(stk_depth),
    .err(stk_err)
  );

  // Sticky events, write one to clear, set wins over a simultaneous clear.
  always_comb begin
    ev_set = 3'h0;
    ev_set[pic_pkg::EV_NMI] = nmi_in && !nmi_q;
    ev_set[pic_pkg::EV_ACK] = ack_take;
    ev_set[pic_pkg::EV_STK] = stk_err;
    next_ev_status = ev_status | ev_set;
    next_ev_mask = ev_mask;
    if (wr_en && (avs_address == pic_pkg::OFF_EVT)) begin
      next_ev_status = (ev_status & ~avs_writedata[2:0]) | ev_set;
    end
    if (wr_en && (avs_address == pic_pkg::OFF_EVMASK)) begin
      next_ev_mask = avs_writedata[2:0];
    end
  end

  // The critical line is only one flop behind its pin and sees no mask or level.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_q <= 1'b0;
      ev_status <= 3'h0;
      ev_mask <= pic_pkg::EVMASK_RST;
    end else begin
      nmi_q <= nmi_in; // R7
      ev_status <= next_ev_status;
      ev_mask <= next_ev_mask;
    end
  end

  assign core_crit = nmi_q;
  assign irq_out = |(ev_status & ev_mask);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_waiting;
    core_irq && !core_ack;
  endsequence

  sequence s_accept;
    core_irq && core_ack;
  endsequence

  property p_vec_hold;
    s_waiting |=> core_irq && $stable(core_vector);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved before ack"); // R8

  property p_ack_level;
    logic [3:0] l;
    (s_accept, l = req_lvl) |=> !core_irq && cpr == l && stk_depth != 5'h00;
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("ack did not raise level"); // R8

  property p_nmi;
    nmi_in |=> core_crit;
  endproperty
  a_nmi: assert property (p_nmi) else $error("critical line late"); // R7

  property p_nmi_low;
    !nmi_in |=> !core_crit;
  endproperty
  a_nmi_low: assert property (p_nmi_low) else $error("critical line stuck"); // R7

  property p_mask;
    win_found |-> win_lvl > cpr && prio_mem[win_idx] == win_lvl;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request won"); // R5

  property p_present;
    !core_irq && win_found |=> core_irq && core_vector[6:0] == $past(win_idx);
  endproperty
  a_present: assert property (p_present) else $error("winner not presented"); // R4

  property p_range;
    core_irq |-> core_vector[8:7] == 2'b00 && req_lvl > 4'h0;
  endproperty
  a_range: assert property (p_range) else $error("bad vector"); // R1

  property p_tie;
    win_found |-> !(pend[0] && prio_mem[0] == win_lvl && win_idx != 7'h00);
  endproperty
  a_tie: assert property (p_tie) else $error("tie order broken"); // R2

  property p_prio_wr;
    logic [6:0] k;
    logic [3:0] v;
    (wr_en && pic_pkg::pic_is_prio(avs_address), k = avs_address[8:2], v = avs_writedata[3:0])
      |=> prio_mem[k] == v;
  endproperty
  a_prio_wr: assert property (p_prio_wr) else $error("level write lost"); // R3

  property p_sw_set;
    wr_en && avs_address == pic_pkg::OFF_SWSET && avs_writedata[0] |=> sw_flag[0];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("soft request not set"); // R6
endmodule
`default_nettype wire

/* hw/pic_level_stack.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_level_stack (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [3:0] push_lvl,
  output logic [3:0] top,
  output logic [4:0] depth,
  output logic err
);
  logic [3:0] mem [pic_pkg::STK_DEPTH];
  logic [4:0] next_depth;
  logic full;
  logic empty;
  logic swap;

  assign full = depth == 5'(pic_pkg::STK_DEPTH);
  assign empty = depth == 5'h00;
  // On a non-empty stack, an end of service and an acknowledge in one cycle cancel out: the level that the
  // pop would restore is the one the new routine must save, so the stack stays put.
  assign swap = push && pop && !empty;
  assign top = empty ? pic_pkg::CPR_RST : mem[4'(depth - 5'h01)];
  // A push when full or a pop when empty is dropped and reported, so nesting never wraps.
  assign err = (push && full && !swap) || (pop && empty);

  // Depth follows pushes and pops; a swap leaves it as it is.
  always_comb begin
    next_depth = depth;
    if (swap) begin
      next_depth = depth;
    end else if (push && !full) begin
      next_depth = depth + 5'h01;
    end else if (pop && !empty) begin
      next_depth = depth - 5'h01;
    end
  end

  // Saved levels are stored only on a real push.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      depth <= 5'h00;
      for (int i = 0; i < pic_pkg::STK_DEPTH; i++) begin
        mem[i] <= pic_pkg::CPR_RST;
      end
    end else begin
      depth <= next_depth;
      if (push && !full && !swap) begin
        mem[4'(depth)] <= push_lvl;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/pic_pkg.sv */
package pic_pkg;
  // Source space: the low sources are software settable, the rest are wired requests.
  localparam int NSRC = 128;
  localparam int NSW = 8;
  localparam int PRIO_W = 4;
  localparam int IDX_W = 7;
  localparam int VEC_W = 9;
  localparam int STK_DEPTH = 16;
  localparam int STK_PTR_W = 5;
  localparam int ADDR_W = 12;

  // Register byte offsets; priority words fill 0x400 to 0x5fc, one per source.
  localparam logic [11:0] OFF_CPR = 12'h000;
  localparam logic [11:0] OFF_VEC = 12'h004;
  localparam logic [11:0] OFF_EOI = 12'h008;
  localparam logic [11:0] OFF_SWSET = 12'h00c;
  localparam logic [11:0] OFF_EVT = 12'h010;
  localparam logic [11:0] OFF_EVMASK = 12'h014;
  localparam logic [2:0] PRIO_PAGE = 3'h2;

  // Field positions.
  localparam int SW_CLR_LSB = 8;
  localparam int VEC_PEND_BIT = 16;
  localparam int VEC_DEPTH_LSB = 24;
  localparam int EV_NMI = 0;
  localparam int EV_ACK = 1;
  localparam int EV_STK = 2;
  localparam int EV_W = 3;

  // Reset values.
  localparam logic [3:0] CPR_RST = 4'h0;
  localparam logic [3:0] PRIO_RST = 4'h0;
  localparam logic [2:0] EVMASK_RST = 3'h0;

  typedef enum {PIC_IDLE, PIC_PRESENT} pic_req_state_t;

  // True when a byte address falls in the per-source priority page.
  function automatic logic pic_is_prio(input logic [11:0] addr);
    return addr[11:9] == PRIO_PAGE;
  endfunction
endpackage
